// File: hw/rtcs_alarm_sup.v
// alarm comparator, square-wave/interrupt output, oscillator-stop flag and reset supervisor
// assumes timekeeping counters outside feed the current time and a synchronous 32.768kHz level
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "rtcs_regs.vh"

module rtcs_alarm_sup #(
  parameter VARIANT = 0,
  parameter RST_HOLD_CYC = `RTCS_MS_TO_CYC(`RTCS_RST_HOLD_MS),
  parameter OSC_START_CYC = `RTCS_MS_TO_CYC(`RTCS_OSC_START_MS),
  parameter DEBOUNCE_CYC = `RTCS_MS_TO_CYC(`RTCS_BUTTON_DEBOUNCE_MS)
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData,
  input wire supplyValid,
  input wire oscLevel,
  input wire oscFault,
  input wire [7:0] timeHundredths,
  input wire [7:0] timeSeconds,
  input wire [7:0] timeMinutes,
  input wire [7:0] timeHours,
  input wire [7:0] timeDay,
  input wire [7:0] timeDate,
  output reg hundredthsTick,
  output reg oscRunEnable,
  output reg powerFail,
  output reg accessBlocked,
  output wire waveOrIrqPinOut,
  output reg waveOrIrqPinOe,
  output wire wavePinOut,
  output reg wavePinOe,
  output wire irqPinOut,
  output reg irqPinOe,
  input wire resetPinIn,
  output wire resetPinOut,
  output reg resetPinOe
);

  // variant 0 combined pin, 1 reset pin only, 2 separate wave and irq pins, 3 combined plus reset
  localparam HAS_COMBINED = (VARIANT == 0) || (VARIANT == 3);
  localparam HAS_SEPARATE = (VARIANT == 2);
  localparam HAS_RESET = (VARIANT == 1) || (VARIANT == 3);

  localparam [1:0] BTN_IDLE = 2'h0;
  localparam [1:0] BTN_PRESS = 2'h1;
  localparam [1:0] BTN_WAIT_UP = 2'h2;
  localparam [1:0] BTN_RELEASE = 2'h3;

  assign waveOrIrqPinOut = 1'b0;
  assign wavePinOut = 1'b0;
  assign irqPinOut = 1'b0;
  assign resetPinOut = 1'b0;

  reg [7:0] control;
  reg [7:0] status;
  reg [7:0] alarmReg [0:4];
  reg [1:0] btnState;
  reg [31:0] btnCnt;
  reg [31:0] holdCnt;
  reg prevResetPin;
  // our own pull as it stood one sample ago, to tell it apart from the button
  reg ownDriveLast;
  reg prevOscRun;
  reg prevOscLevel;
  reg [14:0] oscDiv;
  reg [5:0] hundDiv;
  reg [4:0] hundRun;
  reg evalAlarm;

  wire onBackup = ~supplyValid;
  wire wrOk = regWrStb & ~accessBlocked;
  wire rdOk = regRdStb & ~accessBlocked;
  wire wrAlarm = wrOk && (regAddr[7:3] == `RTCS_WR_ALM_BASE) && (regAddr[2:0] <= `RTCS_ALM_LAST);
  wire rdAlarm = (regAddr[7:3] == `RTCS_RD_ALM_BASE) && (regAddr[2:0] <= `RTCS_ALM_LAST);

  wire oscStopOnBackup = control[`RTCS_CTL_OSC_STOP_ON_BACKUP];
  wire backupOutEn = control[`RTCS_CTL_BACKUP_OUT_EN];
  wire [1:0] rateSel = {control[`RTCS_CTL_RATE_HI], control[`RTCS_CTL_RATE_LO]};
  wire outSelAlarm = control[`RTCS_CTL_OUT_SEL_ALARM];
  wire alarmIrqEn = control[`RTCS_CTL_ALARM_IRQ_EN];
  wire alarmFlag = status[`RTCS_STA_ALARM_MATCH];

  // oscillator: runs on main supply unless oscFault, optionally halted on backup
  wire oscRun = ~(oscStopOnBackup & onBackup) & ~oscFault;

  // alarm registers, one slot per compare field
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : almSlot
      localparam [2:0] SLOT = g;
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          alarmReg[g] <= 8'h00;
        end else if (wrAlarm && regAddr[2:0] == SLOT) begin
          alarmReg[g] <= regWrData;
        end
      end
    end
  endgenerate

  // control register; reset-only variant keeps the low bits as plain storage
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control <= `RTCS_CTL_RESET;
    end else if (wrOk && regAddr == `RTCS_WR_CTRL) begin
      control <= regWrData & `RTCS_CTL_WR_MASK;
    end
  end

  // 32.768kHz edge counter feeds both the square wave and the 4096Hz tick
  wire oscRise = oscLevel & ~prevOscLevel;
  wire tick4096 = oscRise && (oscDiv[2:0] == 3'h7);
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevOscLevel <= 1'b0;
      oscDiv <= 15'h0000;
    end else begin
      prevOscLevel <= oscLevel;
      if (oscRise) begin
        oscDiv <= oscDiv + 15'h0001;
      end
    end
  end

  // divide 4096Hz by 41 for 24 ticks and by 40 once: exact 100Hz every 250ms
  wire [5:0] hundLimit = (hundRun == `RTCS_HUND_LONG_RUNS) ? `RTCS_HUND_SHORT_DIV : `RTCS_HUND_LONG_DIV;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hundDiv <= 6'h00;
      hundRun <= 5'h00;
      hundredthsTick <= 1'b0;
      evalAlarm <= 1'b0;
    end else begin
      hundredthsTick <= 1'b0;
      // compare one cycle after the tick so the counters outside have advanced
      evalAlarm <= hundredthsTick;
      if (tick4096) begin
        if (hundDiv == hundLimit - 6'h01) begin
          hundDiv <= 6'h00;
          hundredthsTick <= 1'b1;
          hundRun <= (hundRun == `RTCS_HUND_LONG_RUNS) ? 5'h00 : hundRun + 5'h01;
        end else begin
          hundDiv <= hundDiv + 6'h01;
        end
      end
    end
  end

  // alarm comparator
  wire [7:0] almHund = alarmReg[0];
  wire [7:0] almSec = alarmReg[1];
  wire [7:0] almMin = alarmReg[2];
  wire [7:0] almHour = alarmReg[3];
  wire [7:0] almDay = alarmReg[4];
  reg hundMatch;
  always @* begin
    if (almHund == `RTCS_HUND_EVERY) begin
      hundMatch = 1'b1;
    end else if (almHund[7:4] == `RTCS_HUND_UNITS_TAG) begin
      hundMatch = (almHund[3:0] == timeHundredths[3:0]);
    end else begin
      hundMatch = (almHund == timeHundredths);
    end
  end
  // masks act field by field; combinations that skip a level are left undefined
  wire secMatch = almSec[`RTCS_ALM_MASK_BIT] | (almSec[6:0] == timeSeconds[6:0]);
  wire minMatch = almMin[`RTCS_ALM_MASK_BIT] | (almMin[6:0] == timeMinutes[6:0]);
  wire hourMatch = almHour[`RTCS_ALM_MASK_BIT] | (almHour[6:0] == timeHours[6:0]);
  wire [5:0] dayTarget = almDay[`RTCS_ALM_DAYSEL_BIT] ? timeDay[5:0] : timeDate[5:0];
  wire dayMatch = almDay[`RTCS_ALM_MASK_BIT] | (almDay[5:0] == dayTarget);
  wire alarmHit = evalAlarm & hundMatch & secMatch & minMatch & hourMatch & dayMatch;
  wire oscStopEvent = prevOscRun & ~oscRun;

  // status flags: a hardware set in the same cycle as a clearing write wins
  wire wrStat = wrOk && regAddr == `RTCS_WR_STAT;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= `RTCS_STA_RESET;
      prevOscRun <= 1'b0;
    end else begin
      prevOscRun <= oscRun;
      if (oscStopEvent) begin
        status[`RTCS_STA_OSC_HALTED] <= 1'b1;
      end else if (wrStat && !regWrData[`RTCS_STA_OSC_HALTED]) begin
        status[`RTCS_STA_OSC_HALTED] <= 1'b0;
      end
      if (alarmHit) begin
        status[`RTCS_STA_ALARM_MATCH] <= 1'b1;
      end else if (wrStat && !regWrData[`RTCS_STA_ALARM_MATCH]) begin
        status[`RTCS_STA_ALARM_MATCH] <= 1'b0;
      end
    end
  end

  // square wave select
  reg wave;
  always @* begin
    case (rateSel)
      `RTCS_RATE_1HZ: wave = oscDiv[14];
      `RTCS_RATE_4K: wave = oscDiv[2];
      `RTCS_RATE_8K: wave = oscDiv[1];
      `RTCS_RATE_32K: wave = oscLevel;
      default: wave = 1'b1;
    endcase
  end

  // open-drain pins: enable high pulls the pin low
  wire outsAlive = supplyValid | backupOutEn;
  wire irqActive = alarmFlag & alarmIrqEn;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waveOrIrqPinOe <= 1'b0;
      wavePinOe <= 1'b0;
      irqPinOe <= 1'b0;
      oscRunEnable <= 1'b0;
    end else begin
      oscRunEnable <= oscRun;
      if (HAS_COMBINED && outsAlive) begin
        if (outSelAlarm) begin
          waveOrIrqPinOe <= irqActive;
        end else begin
          waveOrIrqPinOe <= oscRun & ~wave;
        end
      end else begin
        waveOrIrqPinOe <= 1'b0;
      end
      // separate variant: bit 2 low enables the wave pin
      wavePinOe <= HAS_SEPARATE && outsAlive && !outSelAlarm && oscRun && !wave;
      irqPinOe <= HAS_SEPARATE && outsAlive && irqActive;
    end
  end

  // power-fail hold after main supply returns
  wire [31:0] holdLimit = oscStopOnBackup ? RST_HOLD_CYC + OSC_START_CYC : RST_HOLD_CYC;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerFail <= 1'b1;
      holdCnt <= 32'h00000000;
    end else if (!supplyValid) begin
      powerFail <= 1'b1;
      holdCnt <= 32'h00000000;
    end else if (powerFail) begin
      if (holdCnt >= holdLimit - 32'h00000001) begin
        powerFail <= 1'b0;
      end else begin
        holdCnt <= holdCnt + 32'h00000001;
      end
    end
  end

  // pushbutton debounce on the reset pin
  wire pinFell = prevResetPin & ~resetPinIn;
  wire pinRose = ~prevResetPin & resetPinIn;
  wire btnDone = (btnCnt >= DEBOUNCE_CYC - 1);
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      btnState <= BTN_IDLE;
      btnCnt <= 32'h00000000;
      prevResetPin <= 1'b1;
    end else begin
      prevResetPin <= resetPinIn;
      if (!HAS_RESET || powerFail) begin
        btnState <= BTN_IDLE;
        btnCnt <= 32'h00000000;
      end else begin
        case (btnState)
          BTN_IDLE: begin
            btnCnt <= 32'h00000000;
            if (pinFell) begin
              btnState <= BTN_PRESS;
            end
          end
          BTN_PRESS: begin
            if (btnDone) begin
              btnCnt <= 32'h00000000;
              // pull ends one edge later; the pin shows the button alone a sample after that
              btnState <= BTN_WAIT_UP;
            end else begin
              btnCnt <= btnCnt + 32'h00000001;
            end
          end
          BTN_WAIT_UP: begin
            // samples taken under our own pull would fake a release edge
            if (resetPinOe) begin
              btnState <= BTN_WAIT_UP;
            end else if (ownDriveLast) begin
              // first clean sample: a button already up ends the cycle
              if (resetPinIn) begin
                btnState <= BTN_IDLE;
              end
            end else if (pinRose) begin
              btnState <= BTN_RELEASE;
            end
          end
          BTN_RELEASE: begin
            if (btnDone) begin
              btnState <= BTN_IDLE;
              btnCnt <= 32'h00000000;
            end else begin
              btnCnt <= btnCnt + 32'h00000001;
            end
          end
          default: begin
            btnState <= BTN_IDLE;
          end
        endcase
      end
    end
  end

  // reset pin and access blocking
  wire btnDrive = (btnState == BTN_PRESS) || (btnState == BTN_RELEASE);
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetPinOe <= 1'b0;
      accessBlocked <= 1'b1;
      ownDriveLast <= 1'b0;
    end else begin
      ownDriveLast <= resetPinOe;
      resetPinOe <= HAS_RESET && (powerFail || btnDrive);
      accessBlocked <= powerFail || btnDrive;
    end
  end

  // read port: data stands in the cycle after the strobe only
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (rdOk && rdAlarm) begin
      regRdData <= alarmReg[regAddr[2:0]];
    end else if (rdOk && regAddr == `RTCS_RD_CTRL) begin
      regRdData <= control;
    end else if (rdOk && regAddr == `RTCS_RD_STAT) begin
      regRdData <= status;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

// File: hw/rtcs_regs.vh
// register map, field positions, reset values and timing figures of the alarm and supervisor block
// assumes a 20 MHz ref_clk and a host port that decodes byte addresses (write 8xh, read 0xh)
// Behaviour
// - host writes to 88h..8Ch load the five alarm compare registers
// - bit 7 of alarm seconds..day/date masks; all zero compares every field
// - alarm hundredths FFh fires each tick, F0h..F9h unit digit, BCD both digits
// - clearing masks widens compare seconds, minutes, hours, then day/date
// - alarm day/date bit 6 picks weekday (1) or month date (0) for bits 5..0
// - every alarm match sets the alarm flag regardless of output select
// - combined pin interrupts only while flag, irq enable and output select are one
// - output select zero puts square wave on combined pin, only while oscillator runs
// - rate bits 4:3 pick 1Hz, 4.096kHz, 8.192kHz or 32.768kHz
// - power-up control: stop-on-backup 0, backup enable 0, rate 11, select 0, irq 0
// - on backup supply wave and interrupt outputs stay active only with backup output enable, else released; reset pin stays driven
// - control bit 7 stops oscillator on backup; oscillator runs on main supply unless oscFault
// - oscillator halted flag sets on run-to-stop, clears only by writing zero
// - alarm flag clears only by writing zero; writing one leaves it
// - main supply fault raises power-fail, blocks register access, drives reset pin low
// - power-fail held reset-hold time after recovery, plus oscillator start if bit 7
// - idle reset pin falling edge: drive low, block access one debounce period
// - line still low after debounce: await release, then drive low one more period
// - separate-pin variant: control bit 2 enables wave pin, zero means active
// - reset-only variant: control bits 5..2 and 0 are plain storage
// - hundredths tick divides 4096Hz by 41 for 24 cycles, 40 for one
`ifndef RTCS_REGS_VH
`define RTCS_REGS_VH

`define RTCS_WR_ALM_BASE 5'h11
`define RTCS_RD_ALM_BASE 5'h01
`define RTCS_ALM_LAST 3'h4
`define RTCS_WR_CTRL 8'h8D
`define RTCS_RD_CTRL 8'h0D
`define RTCS_WR_STAT 8'h8E
`define RTCS_RD_STAT 8'h0E

`define RTCS_CTL_OSC_STOP_ON_BACKUP 7
`define RTCS_CTL_BACKUP_OUT_EN 5
`define RTCS_CTL_RATE_HI 4
`define RTCS_CTL_RATE_LO 3
`define RTCS_CTL_OUT_SEL_ALARM 2
`define RTCS_CTL_ALARM_IRQ_EN 0
`define RTCS_CTL_RESET 8'h18
`define RTCS_CTL_WR_MASK 8'hBD
`define RTCS_STA_OSC_HALTED 7
`define RTCS_STA_ALARM_MATCH 0
`define RTCS_STA_RESET 8'h80
`define RTCS_ALM_MASK_BIT 7
`define RTCS_ALM_DAYSEL_BIT 6
`define RTCS_HUND_EVERY 8'hFF
`define RTCS_HUND_UNITS_TAG 4'hF

`define RTCS_RATE_1HZ 2'h0
`define RTCS_RATE_4K 2'h1
`define RTCS_RATE_8K 2'h2
`define RTCS_RATE_32K 2'h3

`define RTCS_HUND_LONG_DIV 6'h29
`define RTCS_HUND_SHORT_DIV 6'h28
`define RTCS_HUND_LONG_RUNS 5'h18

`define RTCS_CLK_HZ 20000000
`define RTCS_RST_HOLD_MS 250
`define RTCS_OSC_START_MS 1000
`define RTCS_BUTTON_DEBOUNCE_MS 250
`define RTCS_MS_TO_CYC(ms) ((ms) * (`RTCS_CLK_HZ / 1000))

`endif

// File: verification/rtcs_alarm_sup_sva.sv
// checker of the alarm and supervisor block at its ports
// assumes VARIANT 3 and open-drain pins resolved with pull-ups
`timescale 1ns/1ps
module rtcs_alarm_sup_sva (
  input wire ref_clk,
  input wire sys_rst,
  input wire regRdStb,
  input wire [7:0] regRdData,
  input wire supplyValid,
  input wire oscFault,
  input wire hundredthsTick,
  input wire oscRunEnable,
  input wire powerFail,
  input wire accessBlocked,
  input wire resetPinIn,
  input wire resetPinOe
);
  // keeps $past away from values taken during reset
  reg [2:0] upCnt;
  wire up = upCnt == 3'h7;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) upCnt <= 3'h0;
    else if (!up) upCnt <= upCnt + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_blocked_read: assert property (regRdStb && accessBlocked |=> regRdData == 8'h00)
    else $error("blocked read gave data");
  a_fail_blocks: assert property (powerFail && up |=> accessBlocked && resetPinOe)
    else $error("power fail not blocking");
  a_supply_fail: assert property (!supplyValid |-> ##[1:3] powerFail)
    else $error("supply loss missed");
  a_hold_after: assert property ($rose(supplyValid) && up |=> powerFail [*8])
    else $error("power fail released early");
  a_osc_main: assert property ((supplyValid && !oscFault && up) [*4] |-> oscRunEnable)
    else $error("oscillator stopped on main supply");
  a_tick_single: assert property (hundredthsTick |=> !hundredthsTick [*8])
    else $error("tick too long or too close");
  a_press_pull: assert property (
    $fell(resetPinIn) && !$past(resetPinOe) && !resetPinOe && !powerFail && !accessBlocked && up
    |-> ##2 resetPinOe && accessBlocked) else $error("press not debounced");
  a_debounce_hold: assert property ($rose(resetPinOe) && !powerFail |=> resetPinOe [*8])
    else $error("debounce pull too short");
  a_release_pull: assert property (
    $rose(resetPinIn) && !$past(resetPinOe) && !powerFail && up |-> ##[1:3] resetPinOe)
    else $error("release not debounced");
  c_tick: cover property (hundredthsTick);
  c_button: cover property ($rose(resetPinOe) && !powerFail);
  c_backup: cover property ($fell(supplyValid));
endmodule
bind rtcs_alarm_sup rtcs_alarm_sup_sva rtcs_alarm_sup_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .regRdStb(regRdStb), .regRdData(regRdData), .supplyValid(supplyValid), .oscFault(oscFault),
  .hundredthsTick(hundredthsTick), .oscRunEnable(oscRunEnable), .powerFail(powerFail),
  .accessBlocked(accessBlocked), .resetPinIn(resetPinIn), .resetPinOe(resetPinOe));

// File: verification/rtcs_alarm_sup_tb.sv
// self-checking bench, combined pin plus reset pin variant
// assumes short hold and debounce counts and an oscillator toggling each cycle
`timescale 1ns/1ps
module rtcs_alarm_sup_tb;
  reg ref_clk, sys_rst, supplyValid, oscLevel, oscFault, buttonUp, p;
  reg [7:0] tHund, tSec, tMin, tHour, tDay, tDate, d;
  wire [7:0] regAddr, regWrData, regRdData;
  wire regWrStb, regRdStb, hundredthsTick, oscRunEnable, powerFail, accessBlocked;
  wire waveOrIrqPinOe, resetPinIn, resetPinOe, waveOrIrqPin;
  integer error_cnt, compares, n, i, e;
  localparam [39:0] H_ALM = 40'hFFF5F54242, H_TIM = 40'h3725264212, H_EXP = 40'h0101000100;
  localparam [31:0] D_ALM = 32'h43440305, D_EXP = 32'h01000001;
  // pin pulls per 512 cycles with the oscillator level toggling each cycle
  localparam [47:0] R_EXP = 48'h000020040100;
  `define CHK(a, x) begin compares = compares + 1; if ((a) !== (x)) begin error_cnt = error_cnt + 1; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (x)); end end
  rtcs_alarm_sup #(.VARIANT(3), .RST_HOLD_CYC(20), .OSC_START_CYC(10), .DEBOUNCE_CYC(16)) rtcs_alarm_sup_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .supplyValid(supplyValid), .oscLevel(oscLevel),
    .oscFault(oscFault), .timeHundredths(tHund), .timeSeconds(tSec), .timeMinutes(tMin), .timeHours(tHour),
    .timeDay(tDay), .timeDate(tDate), .hundredthsTick(hundredthsTick), .oscRunEnable(oscRunEnable),
    .powerFail(powerFail), .accessBlocked(accessBlocked), .waveOrIrqPinOut(), .waveOrIrqPinOe(waveOrIrqPinOe),
    .wavePinOut(), .wavePinOe(), .irqPinOut(), .irqPinOe(), .resetPinIn(resetPinIn), .resetPinOut(),
    .resetPinOe(resetPinOe));
  rtcs_host_model rtcs_host_model_i (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .buttonUp(buttonUp),
    .resetPinOe(resetPinOe), .waveOrIrqPinOe(waveOrIrqPinOe), .resetPinIn(resetPinIn), .waveOrIrqPin(waveOrIrqPin));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // fast oscillator keeps ticks short; frozen while stopped
  always @(posedge ref_clk) if (oscRunEnable === 1'b1) oscLevel <= ~oscLevel;
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    final_report;
  end
  task final_report;
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    rtcs_host_model_i.wr(a, v);
  endtask
  task rdChk(input [7:0] a, input [7:0] x);
    rtcs_host_model_i.rd(a, d);
    `CHK(d, x)
  endtask
  task waitTick;
    for (n = 0; hundredthsTick !== 1'b1 && n < 800; n = n + 1) cyc(1);
    cyc(4);
  endtask
  // first access after unblock goes to an unmapped place
  task waitFree;
    for (n = 0; accessBlocked !== 1'b0 && n < 400; n = n + 1) cyc(1);
    cyc(2);
    `CHK(accessBlocked, 1'b0)
    rdChk(8'h1F, 8'h00);
  endtask
  task rises(input integer k);
    n = 0;
    p = waveOrIrqPinOe;
    repeat (k) begin
      cyc(1);
      if (waveOrIrqPinOe === 1'b1 && p === 1'b0) n = n + 1;
      p = waveOrIrqPinOe;
    end
  endtask
  // new alarm value and flag clear right after a tick, so no tick lands mid-setup
  task probe(input [7:0] a, input [7:0] v, input [7:0] x);
    waitTick;
    wr(a, v);
    wr(8'h8E, 8'h00);
    waitTick;
    rdChk(8'h0E, x);
  endtask
  initial begin
    sys_rst = 1'b1;
    {supplyValid, oscLevel, oscFault, buttonUp} = 4'h9;
    {tHund, tSec, tMin, tHour, tDay, tDate} = 48'h000000000101;
    error_cnt = 0;
    compares = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    waitFree;
    rdChk(8'h0D, 8'h18);
    rdChk(8'h0E, 8'h80);
    wr(8'h8E, 8'hFF);
    rdChk(8'h0E, 8'h80);
    wr(8'h8E, 8'h00);
    rdChk(8'h0E, 8'h00);
    wr(8'h8D, 8'hFF);
    rdChk(8'h0D, 8'hBD);
    wr(8'h8D, 8'h18);
    waitTick;
    for (n = 4; hundredthsTick !== 1'b1 && n < 800; n = n + 1) cyc(1);
    `CHK(n == 656 || n == 640, 1'b1)
    tHund <= 8'h12;
    tSec <= 8'h35;
    wr(8'h88, 8'h12);
    wr(8'h8A, 8'h80);
    wr(8'h8B, 8'h80);
    wr(8'h8C, 8'h80);
    wr(8'h89, 8'h34);
    rdChk(8'h09, 8'h34);
    probe(8'h89, 8'h34, 8'h00);
    tSec <= 8'h34;
    probe(8'h89, 8'h34, 8'h01);
    wr(8'h8E, 8'h01);
    rdChk(8'h0E, 8'h01);
    wr(8'h8E, 8'h00);
    rdChk(8'h0E, 8'h00);
    wr(8'h89, 8'h80);
    for (i = 0; i < 5; i = i + 1) begin
      tHund <= H_TIM[8*(4-i) +: 8];
      probe(8'h88, H_ALM[8*(4-i) +: 8], H_EXP[8*(4-i) +: 8]);
    end
    {tHund, tSec, tDay, tDate} = 32'h00000305;
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    for (i = 0; i < 4; i = i + 1) probe(8'h8C, D_ALM[8*(3-i) +: 8], D_EXP[8*(3-i) +: 8]);
    probe(8'h8A, 8'h01, 8'h00);
    probe(8'h8A, 8'h00, 8'h01);
    wr(8'h8D, 8'h1D);
    cyc(3);
    `CHK(waveOrIrqPin, 1'b0)
    wr(8'h8D, 8'h1C);
    cyc(3);
    `CHK(waveOrIrqPinOe, 1'b0)
    tMin <= 8'h01;
    wr(8'h8D, 8'h1D);
    probe(8'h8E, 8'h00, 8'h00);
    `CHK(waveOrIrqPinOe, 1'b0)
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h8D, {3'h0, i[1:0], 3'h0});
      rises(512);
      e = R_EXP[12*(3-i) +: 12];
      `CHK(n >= e - 1 && n <= e + 1, 1'b1)
    end
    wr(8'h8D, 8'h38);
    supplyValid <= 1'b0;
    rises(64);
    `CHK(n > 8, 1'b1)
    rdChk(8'h0D, 8'h00);
    supplyValid <= 1'b1;
    waitFree;
    wr(8'h8D, 8'h98);
    supplyValid <= 1'b0;
    cyc(4);
    `CHK({oscRunEnable, waveOrIrqPinOe, powerFail, resetPinOe}, 4'h3)
    supplyValid <= 1'b1;
    for (n = 0; powerFail !== 1'b0 && n < 100; n = n + 1) cyc(1);
    `CHK(n >= 29 && n <= 33, 1'b1)
    waitFree;
    rdChk(8'h0E, 8'h80);
    wr(8'h8E, 8'h00);
    buttonUp <= 1'b0;
    cyc(3);
    `CHK({resetPinOe, accessBlocked}, 2'h3)
    buttonUp <= 1'b1;
    cyc(20);
    `CHK(resetPinOe, 1'b0)
    buttonUp <= 1'b0;
    cyc(40);
    `CHK(resetPinOe, 1'b0)
    buttonUp <= 1'b1;
    cyc(4);
    `CHK(resetPinOe, 1'b1)
    cyc(20);
    `CHK(resetPinOe, 1'b0)
    final_report;
  end
endmodule

// File: verification/rtcs_host_model.sv
// host side: register port master and pull-ups of the open-drain pins
// assumes the device never stalls the port
`timescale 1ns/1ps
module rtcs_host_model (
  input wire ref_clk,
  output reg [7:0] regAddr,
  output reg [7:0] regWrData,
  output reg regWrStb,
  output reg regRdStb,
  input wire [7:0] regRdData,
  input wire buttonUp,
  input wire resetPinOe,
  input wire waveOrIrqPinOe,
  output wire resetPinIn,
  output wire waveOrIrqPin
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end
  // a pulled-up line is low while any party pulls it
  assign resetPinIn = buttonUp & ~resetPinOe;
  assign waveOrIrqPin = ~waveOrIrqPinOe;
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule
